/* File: shared/hcs_pkg.sv */
`default_nettype none
package hcs_pkg;
  localparam int          PC_W          = 13;
  localparam int          CTRL_W        = 16;
  localparam int          PORT_W        = 4;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [15:0] CTRL_INIT     = 16'h0000;
  localparam logic [15:0] SYSREG_INIT   = 16'h0000;
  localparam logic [3:0]  STOP_OPERAND  = 4'h0;
  localparam logic [3:0]  IO_DIR_INPUT  = 4'h0;
  localparam int          OSC_WAKE_NS   = 1000;
  localparam int          CLK_NS        = 25;
  localparam int          OSC_WAKE_CYC  = (OSC_WAKE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    HCS_RUN  = 2'b00,
    HCS_HALT = 2'b01,
    HCS_STOP = 2'b10,
    HCS_WAKE = 2'b11
  } hcs_state_t;
endpackage
`default_nettype wire

/* File: shared/hcs_wake_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hcs_wake_if;
  logic start;
  logic done;
  modport ctl (output start, input done);
  modport tmr (input start, output done);
endinterface
`default_nettype wire

/* File: logic/hcs_wake_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module hcs_wake_timer #(
  parameter int CYCLES = hcs_pkg::OSC_WAKE_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  hcs_wake_if.tmr   wk
);
  import hcs_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  // refuse a zero count at elaboration, done would never pulse
  if (CYCLES < 1) begin : g_bad_cycles
    $error("wake count must be at least one cycle");
  end

  // oscillator settling count after restart
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= '0;
      wk.done <= 1'b0;
    end else if (wk.start) begin
      cnt_reg <= CW'(CYCLES);
      wk.done <= 1'b0;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CW'(1);
      wk.done <= (cnt_reg == CW'(1));
    end else begin
      wk.done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: logic/hcs_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - halt stops instruction execution, pc held at halt instruction address
// - while halted peripherals keep running, only instruction stream stops
// - clock stop ceases all peripheral operation, oscillator is off
// - halt keeps control registers; stop instruction reloads their initial values at once
// - peripherals follow held settings in halt, initialized settings in stop
// - stop with chip enable high is a nop; low clears pc and freezes
// - chip enable rising ends clock stop: chip enable reset, oscillator restarts
module hcs_power_ctrl #(
  parameter int WAKE_CYCLES = hcs_pkg::OSC_WAKE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       chip_en,
  input  wire logic                       halt_cmd,
  input  wire logic                       halt_release,
  input  wire logic                       stop_cmd,
  input  wire logic [3:0]                 stop_operand,
  input  wire logic                       pc_step,
  input  wire logic [hcs_pkg::PC_W-1:0]   pc_load_val,
  input  wire logic                       pc_load,
  input  wire logic                       ctrl_we,
  input  wire logic [hcs_pkg::CTRL_W-1:0] ctrl_wdata,
  input  wire logic                       sysreg_we,
  input  wire logic [hcs_pkg::CTRL_W-1:0] sysreg_wdata,
  input  wire logic [hcs_pkg::PORT_W-1:0] io_dir_wdata,
  input  wire logic                       io_dir_we,
  input  wire logic [hcs_pkg::PORT_W-1:0] out_port_wdata,
  input  wire logic                       out_port_we,
  output logic [hcs_pkg::PC_W-1:0]        pc,
  output logic                            cpu_run,
  output logic                            periph_run,
  output logic                            osc_en,
  output logic                            ce_reset,
  output logic                            halted,
  output logic                            stopped,
  output logic [hcs_pkg::CTRL_W-1:0]      ctrl_regs,
  output logic [hcs_pkg::CTRL_W-1:0]      sys_regs,
  output logic [hcs_pkg::PORT_W-1:0]      io_dir,
  output logic [hcs_pkg::PORT_W-1:0]      out_port
);
  import hcs_pkg::*;

  hcs_state_t state_reg;
  hcs_state_t state_next;
  logic       ce_prev_reg;
  logic       stop_take;
  logic       ce_rise;
  hcs_wake_if wk ();

  // pc and register updates only while instructions run, never in the halt cycle
  // one helper keeps that refusal identical for every register
  function automatic logic upd_open(input hcs_state_t st, input logic halt_req);
    upd_open = (st == HCS_RUN) && !halt_req;
  endfunction

  // refuse a zero settling count at elaboration
  if (WAKE_CYCLES < 1) begin : g_bad_wake
    $error("WAKE_CYCLES must be positive");
  end

  // settling counter; the core stays parked until it reports done
  hcs_wake_timer #(
    .CYCLES (WAKE_CYCLES)
  ) u_wake (
    .clk   (clk),
    .reset (reset),
    .wk    (wk)
  );

  // stop accepted only when running with chip enable low; high acts as nop
  // operand is not checked, software owns that encoding
  assign stop_take = (state_reg == HCS_RUN) && stop_cmd && !chip_en;
  assign ce_rise   = chip_en && !ce_prev_reg;
  assign wk.start  = (state_reg == HCS_STOP) && ce_rise;

  // chip enable edge detect; pin is taken as synchronous
  always_ff @(posedge clk) begin
    if (reset) begin
      ce_prev_reg <= 1'b0;
    end else begin
      ce_prev_reg <= chip_en;
    end
  end

  // mode sequencing
  // stop is tested before halt, so it wins when both arrive together
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HCS_RUN: begin
        if (stop_take) begin
          state_next = HCS_STOP;
        end else if (halt_cmd) begin
          state_next = HCS_HALT;
        end
      end
      HCS_HALT: begin
        if (halt_release) begin
          state_next = HCS_RUN;
        end
      end
      HCS_STOP: begin
        if (ce_rise) begin
          state_next = HCS_WAKE;
        end
      end
      HCS_WAKE: begin
        if (wk.done) begin
          state_next = HCS_RUN;
        end
      end
      default: state_next = HCS_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= HCS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // instruction stream flags, registered from next state so they align with it
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_run <= 1'b1;
      halted  <= 1'b0;
    end else begin
      cpu_run <= (state_next == HCS_RUN);
      halted  <= (state_next == HCS_HALT);
    end
  end

  // clock and peripheral flags; wake keeps peripherals off until settled
  always_ff @(posedge clk) begin
    if (reset) begin
      periph_run <= 1'b1;
      osc_en     <= 1'b1;
      stopped    <= 1'b0;
    end else begin
      periph_run <= (state_next == HCS_RUN) || (state_next == HCS_HALT);
      osc_en     <= (state_next != HCS_STOP);
      stopped    <= (state_next == HCS_STOP);
    end
  end

  // one-cycle reset pulse toward the core on wake
  always_ff @(posedge clk) begin
    if (reset) begin
      ce_reset <= 1'b0;
    end else begin
      ce_reset <= wk.start;
    end
  end

  // program counter: frozen in halt, cleared by accepted stop
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= PC_RESET;
    end else if (stop_take) begin
      pc <= PC_RESET;
    end else if (upd_open(state_reg, halt_cmd)) begin
      if (pc_load) begin
        pc <= pc_load_val;
      end else if (pc_step) begin
        pc <= pc + PC_W'(1);
      end
    end
  end

  // peripheral control registers; halt leaves them alone
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_regs <= CTRL_INIT;
    end else if (stop_take) begin
      ctrl_regs <= CTRL_INIT;
    end else if (ctrl_we && upd_open(state_reg, halt_cmd)) begin
      ctrl_regs <= ctrl_wdata;
    end
  end

  // system registers reinitialize on stop
  always_ff @(posedge clk) begin
    if (reset) begin
      sys_regs <= SYSREG_INIT;
    end else if (stop_take) begin
      sys_regs <= SYSREG_INIT;
    end else if (sysreg_we && upd_open(state_reg, halt_cmd)) begin
      sys_regs <= sysreg_wdata;
    end
  end

  // ports: bidirectional go input, output-only latches keep last value
  always_ff @(posedge clk) begin
    if (reset) begin
      io_dir <= IO_DIR_INPUT;
    end else if (stop_take) begin
      io_dir <= IO_DIR_INPUT;
    end else if (io_dir_we && upd_open(state_reg, halt_cmd)) begin
      io_dir <= io_dir_wdata;
    end
  end

  // no reset on stop: outputs must hold across clock stop
  always_ff @(posedge clk) begin
    if (reset) begin
      out_port <= '0;
    end else if (out_port_we && upd_open(state_reg, halt_cmd) && !stop_take) begin
      out_port <= out_port_wdata;
    end
  end

  // stop_operand is accepted as-is; a wrong value is undefined by design
  logic unused_ok;
  assign unused_ok = ^stop_operand;
endmodule
`default_nettype wire

/* File: tb/hcs_ce_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module hcs_ce_ctrl (
  input  wire logic clk,
  input  wire logic ce_req,
  output logic      chip_en
);
  // pin moves only on an edge, so the device sees a clean synchronous level
  always_ff @(posedge clk) begin
    chip_en <= ce_req;
  end
endmodule
`default_nettype wire

/* File: tb/hcs_power_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module hcs_power_ctrl_asserts #(
  parameter int WAKE_CYCLES = hcs_pkg::OSC_WAKE_CYC
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        chip_en,
  input wire logic        halt_cmd,
  input wire logic        stop_cmd,
  input wire logic [12:0] pc,
  input wire logic        cpu_run,
  input wire logic        periph_run,
  input wire logic        osc_en,
  input wire logic        ce_reset,
  input wire logic        halted,
  input wire logic        stopped,
  input wire logic [15:0] ctrl_regs
);
  // cpu resumes one edge after the settling count runs out
  localparam int WAKE_LAST = WAKE_CYCLES + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // entry into stop and halt, taken only from run
  stop_init_a: assert property (
    stop_cmd && !chip_en && cpu_run |=> stopped && pc == 13'h0 && ctrl_regs == 16'h0)
    else $error("stop entry wrong");
  stop_nop_a: assert property (
    stop_cmd && chip_en && cpu_run |=> !stopped) else $error("stop not ignored");
  halt_entry_a: assert property (
    halt_cmd && cpu_run && !(stop_cmd && !chip_en) |=>
      halted && !cpu_run && $stable(pc) && $stable(ctrl_regs))
    else $error("halt entry wrong");
  // settings frozen while halted; peripherals and oscillator run in halt, off in stop
  halt_hold_a: assert property (
    halted && $past(halted) |-> $stable(pc) && $stable(ctrl_regs)) else $error("halt drift");
  halt_periph_a: assert property (
    halted |-> periph_run && osc_en) else $error("periph stopped in halt");
  stop_periph_a: assert property (
    stopped |-> !periph_run && !osc_en && !cpu_run) else $error("periph running in stop");
  // wake path: one reset pulse, short settling, then run
  ce_rise_a: assert property (
    stopped && $rose(chip_en) |=> ce_reset && !stopped && osc_en) else $error("no wake");
  ce_pulse_a: assert property (
    ce_reset |=> !ce_reset) else $error("ce reset too long");
  wake_run_a: assert property (
    $fell(stopped) |-> !cpu_run ##WAKE_LAST $rose(cpu_run)) else $error("wake timing wrong");
  cover property (halted ##1 !halted);
  cover property (stopped);
  cover property (ce_reset);
endmodule
bind hcs_power_ctrl hcs_power_ctrl_asserts #(
  .WAKE_CYCLES (WAKE_CYCLES)
) u_hcs_power_ctrl_asserts (.*);
`default_nettype wire

/* File: tb/halt_clock_stop_power_modes_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("FAIL %0t got %h exp %h", $time, a, b); end end
module halt_clock_stop_power_modes_bench;
  import hcs_pkg::*;
  logic        clk = 1'h0, reset = 1'h1, ce_req = 1'h1, halt_cmd = 1'h0, stop_cmd = 1'h0;
  logic        halt_release = 1'h0, pc_step = 1'h0, pc_load = 1'h0, ctrl_we = 1'h0;
  logic        sysreg_we = 1'h0, io_dir_we = 1'h0, out_port_we = 1'h0;
  logic [3:0]  stop_operand = 4'h0, io_dir_wdata = 4'h0, out_port_wdata = 4'h0;
  logic [12:0] pc_load_val = 13'h0, pc;
  logic [15:0] ctrl_wdata = 16'h0, sysreg_wdata = 16'h0, ctrl_regs, sys_regs;
  logic [3:0]  io_dir, out_port;
  logic        chip_en, cpu_run, periph_run, osc_en, ce_reset, halted, stopped;
  int          bad_count = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  // short settling keeps the wake walk within a few cycles
  hcs_power_ctrl #(.WAKE_CYCLES(2)) u_hcs_power_ctrl (.*);
  hcs_ce_ctrl u_hcs_ce_ctrl (.*);
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("compares %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // halt with writes and pc steps attempted while frozen
  task automatic t_halt;
    step;
    pc_load <= 1'h1;
    pc_load_val <= 13'h0123;
    ctrl_we <= 1'h1;
    ctrl_wdata <= 16'h5a5a;
    step;
    pc_load <= 1'h0;
    halt_cmd <= 1'h1;
    ctrl_wdata <= 16'hffff;
    step;
    halt_cmd <= 1'h0;
    pc_step <= 1'h1;
    step(3);
    #1;
    `CHK(halted, 1'h1)
    `CHK(pc, 13'h0123)
    `CHK(periph_run, 1'h1)
    `CHK(ctrl_regs, 16'h5a5a)
    step;
    ctrl_we <= 1'h0;
    pc_step <= 1'h0;
    halt_release <= 1'h1;
    step;
    halt_release <= 1'h0;
    step(2);
    #1;
    `CHK(cpu_run, 1'h1)
  endtask
  // stop ignored with pin high, then taken with pin low, then woken
  task automatic t_stop;
    step;
    stop_cmd <= 1'h1;
    ce_req <= 1'h0;
    step;
    stop_cmd <= 1'h0;
    #1;
    `CHK(stopped, 1'h0)
    step;
    sysreg_we <= 1'h1;
    sysreg_wdata <= 16'h00c3;
    io_dir_we <= 1'h1;
    io_dir_wdata <= 4'ha;
    out_port_we <= 1'h1;
    out_port_wdata <= 4'h5;
    step;
    sysreg_we <= 1'h0;
    io_dir_we <= 1'h0;
    out_port_we <= 1'h0;
    stop_cmd <= 1'h1;
    stop_operand <= STOP_OPERAND;
    step;
    stop_cmd <= 1'h0;
    #1;
    `CHK({stopped, osc_en, periph_run}, 3'h4)
    `CHK({pc, ctrl_regs}, 29'h0)
    `CHK({sys_regs, io_dir, out_port}, 24'h5)
    step(3);
    ce_req <= 1'h1;
    step(2);
    #1;
    `CHK({ce_reset, osc_en}, 2'h3)
    step(6);
    #1;
    `CHK({cpu_run, periph_run}, 2'h3)
  endtask
  initial begin
    step(20);
    reset <= 1'h0;
    t_halt;
    t_stop;
    stop_test;
  end
  initial begin
    step(2000);
    bad_count++;
    stop_test;
  end
endmodule
`default_nettype wire
